// >>> dbs_pkg.sv
// Shared constants, codes and types for the dynamic bus sizer processor-side block.
package dbs_pkg;

   // ==========================================================================
   // Widths
   localparam int PROC_W = 32;
   localparam int PER_W  = 16;

   // ==========================================================================
   // Transfer size codes {hi, lo}
   localparam logic [1:0] SIZ_BYTE = 2'h1;
   localparam logic [1:0] SIZ_WORD = 2'h2;

   // ==========================================================================
   // Port size acknowledge codes {hi, lo}, pin levels (low is asserted)
   localparam logic [1:0] ACK_P32  = 2'h0;
   localparam logic [1:0] ACK_P16  = 2'h1;
   localparam logic [1:0] ACK_P8   = 2'h2;
   localparam logic [1:0] ACK_WAIT = 2'h3;

   // ==========================================================================
   // Half-clock state numbers on the processor side
   localparam logic [7:0] DS_IDLE     = 8'h00;
   localparam logic [7:0] DS_RECOG    = 8'h02;
   localparam logic [7:0] DS_ACK      = 8'h06;
   localparam logic [7:0] DS_ACK_HOLD = 8'h08;
   localparam logic [7:0] DS_MAX      = 8'hff;

   // ==========================================================================
   // Reset and idle levels, read lane enables and transfer counts
   localparam logic [3:0] LANES_FLOAT = 4'hf;
   localparam logic [3:0] LANES_ALL   = 4'h0;
   localparam logic [3:0] LANES_UPPER = 4'h3;
   localparam logic [1:0] PA_RESET    = 2'h0;
   localparam logic [2:0] XFER_ZERO   = 3'h0;
   localparam logic [2:0] XFER_ONE    = 3'h1;
   localparam logic [2:0] XFER_TWO    = 3'h2;
   localparam logic [2:0] XFER_FOUR   = 3'h4;

   // ==========================================================================
   // Types
   typedef struct packed {
      logic       rd;
      logic [1:0] siz;
      logic [1:0] addr;
   } dbs_ctrl_s;

   typedef enum logic [2:0] {
      M_IDLE = 3'b001,
      M_XFER = 3'b010,
      M_ACK  = 3'b100
   } dbs_mst_e;

   typedef enum logic [3:0] {
      P_IDLE   = 4'b0001,
      P_ADDR   = 4'b0010,
      P_STROBE = 4'b0100,
      P_END    = 4'b1000
   } dbs_pst_e;

endpackage

// >>> dbs_sizer.sv
// Processor-side sequencer of the 32-bit to 32/16/8-bit dynamic bus sizer.
`timescale 1ns/1ps

module dbs_sizer (
   // Clock and reset
   input  wire logic        CLK_SYS_I,
   input  wire logic        RESETN_I,
   // Bus clock, sampled
   input  wire logic        BCLK_I,
   // Processor side
   input  wire logic        CS_N_I,
   input  wire logic        RW_I,
   input  wire logic        PROC_ADDR_BIT1_I,
   input  wire logic        PROC_ADDR_BIT0_I,
   input  wire logic        XFER_SIZE_HI_I,
   input  wire logic        XFER_SIZE_LO_I,
   input  wire logic [31:0] PROC_DATA_BUS_I,
   output logic      [31:0] PROC_DATA_BUS_O,
   output logic      [3:0]  PROC_DATA_BUS_OE_N_O,
   output logic             TRANSFER_ACK_OUT_N_O,
   output logic             XCVR_EN_N_O,
   // Peripheral side
   input  wire logic        PORT_SIZE_ACK_HI_N_I,
   input  wire logic        PORT_SIZE_ACK_LO_N_I,
   input  wire logic [15:0] PERIPH_DATA_UPPER_I,
   output logic      [15:0] PERIPH_DATA_UPPER_O,
   output logic             PERIPH_DATA_UPPER_OE_N_O,
   output logic             PERIPH_ADDR_BIT1_O,
   output logic             PERIPH_ADDR_BIT0_O,
   output logic             PERIPH_DATA_STROBE_N_O
);

   // ==========================================================================
   // Helpers
   function automatic logic [7:0] byte_of(input logic [31:0] w, input logic [1:0] idx);
      byte_of = 8'h00;
      for (int i = 0; i < 4; i++) begin
         if (2'(i) == idx) begin
            byte_of = w[31 - 8*i -: 8];
         end
      end
   endfunction

   function automatic logic [31:0] put_byte(input logic [31:0] w, input logic [1:0] idx,
                                            input logic [7:0] b);
      put_byte = w;
      for (int i = 0; i < 4; i++) begin
         if (2'(i) == idx) begin
            put_byte[31 - 8*i -: 8] = b;
         end
      end
   endfunction

   // Transfers needed for an operand size on a port size.
   function automatic logic [2:0] n_xfers(input logic [1:0] siz, input logic [1:0] port);
      if (port == dbs_pkg::ACK_P32 || siz == dbs_pkg::SIZ_BYTE) begin
         n_xfers = dbs_pkg::XFER_ONE;
      end else if (port == dbs_pkg::ACK_P16) begin
         n_xfers = (siz == dbs_pkg::SIZ_WORD) ? dbs_pkg::XFER_ONE : dbs_pkg::XFER_TWO;
      end else begin
         n_xfers = (siz == dbs_pkg::SIZ_WORD) ? dbs_pkg::XFER_TWO : dbs_pkg::XFER_FOUR;
      end
   endfunction

   // ==========================================================================
   // State
   dbs_pkg::dbs_mst_e  mst, next_mst;
   dbs_pkg::dbs_pst_e  pst, next_pst;
   dbs_pkg::dbs_ctrl_s ctrl, next_ctrl;
   logic [7:0]  ds_cnt, next_ds_cnt;
   logic [31:0] wr_data, next_wr_data;
   logic [31:0] rd_data, next_rd_data;
   logic [1:0]  port, next_port;
   logic        port_known, next_port_known;
   logic [1:0]  ack_prev, next_ack_prev;
   logic [1:0]  pa, next_pa;
   logic [2:0]  xfer_cnt, next_xfer_cnt;
   logic        bclk_d;
   logic        ta_n, next_ta_n;
   logic [3:0]  d_oe_n, next_d_oe_n;
   logic [15:0] pd_o, next_pd_o;
   logic        pd_oe_n, next_pd_oe_n;
   logic        ds_n, next_ds_n;
   logic        xcvr_n, next_xcvr_n;

   logic        rise, fall;
   logic [1:0]  ack, eff_port;

   assign rise     = BCLK_I & ~bclk_d;
   assign fall     = ~BCLK_I & bclk_d;
   assign ack      = {PORT_SIZE_ACK_HI_N_I, PORT_SIZE_ACK_LO_N_I};
   assign eff_port = port_known ? port : ack;

   // ==========================================================================
   // Sequencer
   always_comb begin
      next_mst        = mst;
      next_pst        = pst;
      next_ctrl       = ctrl;
      next_ds_cnt     = ds_cnt;
      next_wr_data    = wr_data;
      next_rd_data    = rd_data;
      next_port       = port;
      next_port_known = port_known;
      next_ack_prev   = ack_prev;
      next_pa         = pa;
      next_xfer_cnt   = xfer_cnt;
      next_ta_n       = ta_n;
      next_d_oe_n     = d_oe_n;
      next_pd_o       = pd_o;
      next_pd_oe_n    = pd_oe_n;
      next_ds_n       = ds_n;
      next_xcvr_n     = xcvr_n;
      if (mst != dbs_pkg::M_IDLE && (rise || fall) && ds_cnt != dbs_pkg::DS_MAX) begin
         next_ds_cnt = ds_cnt + 8'h01;
      end
      case (mst)
         dbs_pkg::M_IDLE: begin
            // Inputs are sampled on the system clock, so a chip select that moves
            // close to the bus clock edge is simply taken at the next one.
            if (rise && !CS_N_I) begin
               next_mst        = dbs_pkg::M_XFER;
               next_pst        = dbs_pkg::P_ADDR;
               next_ds_cnt     = dbs_pkg::DS_RECOG;
               next_ctrl       = '{rd: RW_I, siz: {XFER_SIZE_HI_I, XFER_SIZE_LO_I},
                                   addr: {PROC_ADDR_BIT1_I, PROC_ADDR_BIT0_I}};
               next_wr_data    = PROC_DATA_BUS_I;
               next_pa         = {PROC_ADDR_BIT1_I, PROC_ADDR_BIT0_I};
               next_port_known = 1'b0;
               next_xfer_cnt   = dbs_pkg::XFER_ZERO;
               next_pd_o       = {byte_of(PROC_DATA_BUS_I, next_pa),
                                  byte_of(PROC_DATA_BUS_I, next_pa | 2'h1)};
               next_pd_oe_n    = RW_I;
            end
         end
         dbs_pkg::M_XFER: begin
            if (rise && CS_N_I) begin
               // Abort: read data collected so far stays in rd_data; strobe, upper lane drive and transceiver are released.
               next_mst     = dbs_pkg::M_IDLE;
               next_pst     = dbs_pkg::P_IDLE;
               next_ds_cnt  = dbs_pkg::DS_IDLE;
               next_ds_n    = 1'b1;
               next_pd_oe_n = 1'b1;
               next_xcvr_n  = 1'b1;
            end else begin
               case (pst)
                  dbs_pkg::P_ADDR: begin
                     if (fall) begin
                        next_ds_n     = 1'b0;
                        next_ack_prev = ack;
                        next_pst      = dbs_pkg::P_STROBE;
                     end
                  end
                  dbs_pkg::P_STROBE: begin
                     // The pair must match on two falling edges before it counts.
                     if (fall && ack == ack_prev && ack != dbs_pkg::ACK_WAIT) begin
                        next_ds_n     = 1'b1;
                        next_pst      = dbs_pkg::P_END;
                        next_xfer_cnt = xfer_cnt + dbs_pkg::XFER_ONE;
                        if (!port_known) begin
                           next_port       = ack;
                           next_port_known = 1'b1;
                           next_xcvr_n     = (ack != dbs_pkg::ACK_P32);
                        end
                        if (eff_port == dbs_pkg::ACK_P8) begin
                           next_rd_data = put_byte(rd_data, pa, PERIPH_DATA_UPPER_I[15:8]);
                        end else begin
                           next_rd_data = put_byte(put_byte(rd_data, {pa[1], 1'b0},
                                          PERIPH_DATA_UPPER_I[15:8]), {pa[1], 1'b1},
                                          PERIPH_DATA_UPPER_I[7:0]);
                        end
                     end else if (fall) begin
                        next_ack_prev = ack;
                     end
                  end
                  dbs_pkg::P_END: begin
                     if (rise && xfer_cnt == n_xfers(ctrl.siz, port)) begin
                        next_mst     = dbs_pkg::M_ACK;
                        // Waits and extra transfers stretch the access, so the
                        // acknowledge is always numbered DS6 and DS8 counts from it.
                        next_ds_cnt  = dbs_pkg::DS_ACK;
                        next_pst     = dbs_pkg::P_IDLE;
                        next_ta_n    = 1'b0;
                        next_pd_oe_n = 1'b1;
                        if (ctrl.rd) begin
                           next_d_oe_n = (port == dbs_pkg::ACK_P32) ?
                                         dbs_pkg::LANES_UPPER : dbs_pkg::LANES_ALL;
                        end
                     end else if (rise) begin
                        next_pa   = (port == dbs_pkg::ACK_P8) ? pa + 2'h1 : pa + 2'h2;
                        next_pst  = dbs_pkg::P_ADDR;
                        next_pd_o = {byte_of(wr_data, next_pa),
                                     byte_of(wr_data, next_pa | 2'h1)};
                     end
                  end
                  default: begin
                     next_pst = dbs_pkg::P_IDLE;
                  end
               endcase
            end
         end
         dbs_pkg::M_ACK: begin
            // Before the DS8 edge only that edge may end the acknowledge; after
            // it, the negation follows chip select on the next system clock.
            if (CS_N_I && (ds_cnt >= dbs_pkg::DS_ACK_HOLD ||
                (rise && ds_cnt == dbs_pkg::DS_ACK_HOLD - 8'h01))) begin
               next_mst    = dbs_pkg::M_IDLE;
               next_ds_cnt = dbs_pkg::DS_IDLE;
               next_ta_n   = 1'b1;
               next_d_oe_n = dbs_pkg::LANES_FLOAT;
               next_xcvr_n = 1'b1;
            end
         end
         default: begin
            next_mst = dbs_pkg::M_IDLE;
         end
      endcase
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (!RESETN_I) begin
         mst        <= dbs_pkg::M_IDLE;
         pst        <= dbs_pkg::P_IDLE;
         ctrl       <= '0;
         ds_cnt     <= dbs_pkg::DS_IDLE;
         wr_data    <= '0;
         rd_data    <= '0;
         port       <= dbs_pkg::ACK_WAIT;
         port_known <= 1'b0;
         ack_prev   <= dbs_pkg::ACK_WAIT;
         pa         <= dbs_pkg::PA_RESET;
         xfer_cnt   <= dbs_pkg::XFER_ZERO;
         bclk_d     <= 1'b0;
         ta_n       <= 1'b1;
         d_oe_n     <= dbs_pkg::LANES_FLOAT;
         pd_o       <= '0;
         pd_oe_n    <= 1'b1;
         ds_n       <= 1'b1;
         xcvr_n     <= 1'b1;
      end else begin
         mst        <= next_mst;
         pst        <= next_pst;
         ctrl       <= next_ctrl;
         ds_cnt     <= next_ds_cnt;
         wr_data    <= next_wr_data;
         rd_data    <= next_rd_data;
         port       <= next_port;
         port_known <= next_port_known;
         ack_prev   <= next_ack_prev;
         pa         <= next_pa;
         xfer_cnt   <= next_xfer_cnt;
         bclk_d     <= BCLK_I;
         ta_n       <= next_ta_n;
         d_oe_n     <= next_d_oe_n;
         pd_o       <= next_pd_o;
         pd_oe_n    <= next_pd_oe_n;
         ds_n       <= next_ds_n;
         xcvr_n     <= next_xcvr_n;
      end
   end

   assign PROC_DATA_BUS_O          = rd_data;
   assign PROC_DATA_BUS_OE_N_O     = d_oe_n;
   assign TRANSFER_ACK_OUT_N_O     = ta_n;
   assign XCVR_EN_N_O              = xcvr_n;
   assign PERIPH_DATA_UPPER_O      = pd_o;
   assign PERIPH_DATA_UPPER_OE_N_O = pd_oe_n;
   assign PERIPH_ADDR_BIT1_O       = pa[1];
   assign PERIPH_ADDR_BIT0_O       = pa[0];
   assign PERIPH_DATA_STROBE_N_O   = ds_n;

   // ==========================================================================
   // Checks
   chk_idle_quiet: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
      (mst == dbs_pkg::M_IDLE) |-> (ta_n && d_oe_n == dbs_pkg::LANES_FLOAT))
      else $error("Idle bus not quiet");
   chk_wdata_capture: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
      (mst == dbs_pkg::M_IDLE && rise && !CS_N_I) |=> (wr_data == $past(PROC_DATA_BUS_I)))
      else $error("Write data not captured at recognition");
   chk_abort_no_ack: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
      (mst == dbs_pkg::M_XFER && rise && CS_N_I) |=> (mst == dbs_pkg::M_IDLE && ta_n && ds_n))
      else $error("Abort did not end access");
   chk_ack_at_six: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
      $fell(ta_n) |-> (ds_cnt == dbs_pkg::DS_ACK && $past(pst) == dbs_pkg::P_END))
      else $error("Acknowledge not in DS6");
   chk_ack_held: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
      (!ta_n && ds_cnt < dbs_pkg::DS_ACK_HOLD && !rise) |=> !ta_n)
      else $error("Acknowledge dropped before DS8");
   chk_sync_negate: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
      (mst == dbs_pkg::M_ACK && rise && CS_N_I && ds_cnt == dbs_pkg::DS_ACK_HOLD - 8'h01)
      |=> ta_n)
      else $error("Acknowledge not negated at DS8 edge");
   chk_late_float: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
      (mst == dbs_pkg::M_ACK && ds_cnt >= dbs_pkg::DS_ACK_HOLD && CS_N_I)
      |=> (ta_n && d_oe_n == dbs_pkg::LANES_FLOAT))
      else $error("Late negation not followed");
   chk_xfer_count: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
      $fell(ta_n) |-> (xfer_cnt == n_xfers(ctrl.siz, port)))
      else $error("Wrong number of transfers");
   chk_byte_lane: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I)
      (!pd_oe_n && !ds_n) |-> (pd_o[15:8] == byte_of(wr_data, pa)))
      else $error("Upper lane carries wrong byte");

endmodule

// >>> dbs_periph_model.sv
// Peripheral port model that answers the sizer's strobes with a chosen port size.
`timescale 1ns/1ps

module dbs_periph_model (
   // Bus clock
   input  wire logic        bclk_i,
   // Sizer peripheral outputs
   input  wire logic        strobe_n_i,
   input  wire logic [1:0]  pa_i,
   input  wire logic [15:0] pd_i,
   input  wire logic        pd_oe_n_i,
   // Behaviour chosen by the bench
   input  wire logic [1:0]  code_i,
   input  wire logic [3:0]  waits_i,
   input  wire logic [31:0] rd_word_i,
   // Answers to the sizer, and the written word for the bench
   output logic             ack_hi_n_o,
   output logic             ack_lo_n_o,
   output logic      [15:0] pd_o,
   output logic      [31:0] wr_word_o
);
   // ==========================================================================
   // Acknowledge pair
   logic [3:0]  wcnt = 4'h0;
   logic [15:0] last = 16'h0;

   logic [1:0]  ack_pair = dbs_pkg::ACK_WAIT;
   logic [31:0] wr_word = 32'h0;

   assign {ack_hi_n_o, ack_lo_n_o} = ack_pair;
   assign wr_word_o = wr_word;

   // The pair is held steady while the strobe stays low, so two falls see it.
   always @(posedge bclk_i) begin
      if (strobe_n_i) begin
         wcnt <= 4'h0;
         ack_pair <= dbs_pkg::ACK_WAIT;
      end else if (wcnt < waits_i) begin
         wcnt <= wcnt + 4'h1;
      end else begin
         ack_pair <= code_i;
      end
      last <= pd_o;
   end

   // ==========================================================================
   // Data lanes
   function automatic logic [7:0] byte_of(input logic [1:0] idx);
      byte_of = rd_word_i[31 - 8 * int'(idx) -: 8];
   endfunction

   // A released bus toggles every bus clock so stale data cannot pass as fresh.
   always_comb begin
      if (strobe_n_i) begin
         pd_o = ~last;
      end else if (code_i == dbs_pkg::ACK_P8) begin
         pd_o = {byte_of(pa_i), ~last[7:0]};
      end else begin
         pd_o = {byte_of(pa_i & 2'h2), byte_of(pa_i | 2'h1)};
      end
   end

   always @(posedge strobe_n_i) begin
      if (pd_oe_n_i === 1'b0) begin
         if (code_i == dbs_pkg::ACK_P8) begin
            wr_word[31 - 8 * int'(pa_i) -: 8] <= pd_i[15:8];
         end else begin
            wr_word[31 - 8 * int'(pa_i & 2'h2) -: 16] <= pd_i;
         end
      end
   end
endmodule

// >>> dbs_sizer_tb.sv
// Self-checking bench for the processor-side bus sizer with a peripheral port model.
`timescale 1ns/1ps

module dbs_sizer_tb;
   // ==========================================================================
   // Signals
   logic        clk = 1'b0;
   logic        resetn = 1'b0;
   logic        bclk = 1'b0;
   logic        cs_n = 1'b1;
   logic        rw = 1'b1;
   logic [1:0]  addr = 2'h0;
   logic [1:0]  siz = 2'h0;
   logic [31:0] wdat = 32'h0;
   logic [1:0]  code = dbs_pkg::ACK_P8;
   logic [3:0]  waits = 4'h0;
   logic [31:0] rd_word = 32'h8badf00d;
   logic [31:0] dbus;
   logic [3:0]  dbus_oe_n;
   logic        ta_n;
   logic        xcvr_n;
   logic        ack_hi_n;
   logic        ack_lo_n;
   logic [15:0] pd_to_dut;
   logic [15:0] pd_from_dut;
   logic        pd_oe_n;
   logic        pa1;
   logic        pa0;
   logic        strobe_n;
   logic [31:0] wr_word;
   int          err_total = 0;
   int          checked = 0;
   int          cycles = 0;
   int          bdiv = 0;

   always #2 clk = ~clk;

   // The bus clock runs at one eighth of the system clock.
   always @(posedge clk) begin
      bdiv <= (bdiv + 1) % 4;
      if (bdiv == 3) begin
         bclk <= ~bclk;
      end
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         err_total++;
         wrap_up();
      end
   end

   dbs_sizer u_dut (
      .CLK_SYS_I(clk), .RESETN_I(resetn), .BCLK_I(bclk), .CS_N_I(cs_n), .RW_I(rw),
      .PROC_ADDR_BIT1_I(addr[1]), .PROC_ADDR_BIT0_I(addr[0]),
      .XFER_SIZE_HI_I(siz[1]), .XFER_SIZE_LO_I(siz[0]), .PROC_DATA_BUS_I(wdat),
      .PROC_DATA_BUS_O(dbus), .PROC_DATA_BUS_OE_N_O(dbus_oe_n),
      .TRANSFER_ACK_OUT_N_O(ta_n), .XCVR_EN_N_O(xcvr_n),
      .PORT_SIZE_ACK_HI_N_I(ack_hi_n), .PORT_SIZE_ACK_LO_N_I(ack_lo_n),
      .PERIPH_DATA_UPPER_I(pd_to_dut), .PERIPH_DATA_UPPER_O(pd_from_dut),
      .PERIPH_DATA_UPPER_OE_N_O(pd_oe_n), .PERIPH_ADDR_BIT1_O(pa1),
      .PERIPH_ADDR_BIT0_O(pa0), .PERIPH_DATA_STROBE_N_O(strobe_n)
   );

   dbs_periph_model u_periph (
      .bclk_i(bclk), .strobe_n_i(strobe_n), .pa_i({pa1, pa0}), .pd_i(pd_from_dut),
      .pd_oe_n_i(pd_oe_n), .code_i(code), .waits_i(waits), .rd_word_i(rd_word),
      .ack_hi_n_o(ack_hi_n), .ack_lo_n_o(ack_lo_n), .pd_o(pd_to_dut), .wr_word_o(wr_word)
   );

   // ==========================================================================
   // Helpers
   task automatic tick();
      @(posedge clk);
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   function automatic logic [1:0] pick(input int i);
      pick = (i == 0) ? dbs_pkg::ACK_P8 : (i == 1) ? dbs_pkg::ACK_P16 : dbs_pkg::ACK_P32;
   endfunction

   // Control and data stay put until acknowledge unless garble inverts wdat, rw and siz after 24 system clocks.
   task automatic access(input dbs_pkg::dbs_ctrl_s c, input logic [31:0] wd, input int hold,
                         input bit garble, output logic [31:0] rdata, output logic [3:0] oe);
      int n;
      n = 0;
      while (bclk !== 1'b0) tick();
      cs_n <= 1'b0;
      rw <= c.rd;
      addr <= c.addr;
      siz <= c.siz;
      wdat <= wd;
      while (ta_n !== 1'b0 && n < 800) begin
         tick();
         n++;
         if (garble && n == 24) begin
            wdat <= ~wd;
            rw <= ~c.rd;
            siz <= ~c.siz;
         end
      end
      chk(32'(n < 800), 32'h1);
      tick();
      rdata = dbus;
      oe = dbus_oe_n;
      repeat (hold) begin
         chk({31'h0, ta_n}, 32'h0);
         tick();
      end
      cs_n <= 1'b1;
      n = 0;
      while (ta_n !== 1'b1 && n < 16) begin
         tick();
         n++;
      end
      chk(32'(n < ((hold > 0) ? 3 : 16)), 32'h1);
      tick();
      chk({28'h0, dbus_oe_n}, {28'h0, dbs_pkg::LANES_FLOAT});
      repeat (10) tick();
   endtask

   // ==========================================================================
   // Scenarios
   task automatic t_reset();
      chk({24'h0, ta_n, dbus_oe_n, pd_oe_n, strobe_n, xcvr_n}, 32'h000000ff);
      $display("test reset done");
   endtask

   task automatic t_write();
      logic [31:0] r;
      logic [3:0]  oe;
      logic [31:0] w;
      logic [31:0] m;
      for (int i = 0; i < 3; i++) begin
         w = 32'h11223344 * (i + 1);
         code <= pick(i);
         access('{1'b0, 2'h0, 2'h0}, w, 0, i == 0, r, oe);
         m = (i == 2) ? 32'hffff0000 : 32'hffffffff;
         chk(wr_word & m, w & m);
      end
      code <= dbs_pkg::ACK_P8;
      access('{1'b0, dbs_pkg::SIZ_BYTE, 2'h2}, 32'h0000c300, 0, 1'b0, r, oe);
      chk({24'h0, wr_word[15:8]}, 32'h000000c3);
      $display("test write done");
   endtask

   task automatic t_read();
      logic [31:0] r;
      logic [3:0]  oe;
      logic [31:0] w;
      logic [31:0] m;
      for (int i = 0; i < 3; i++) begin
         w = 32'h8badf00d * (i + 3);
         rd_word <= w;
         code <= pick(i);
         waits <= 4'(2 * i);
         access('{1'b1, 2'h0, 2'h0}, 32'h0, 0, 1'b0, r, oe);
         m = (i == 2) ? 32'hffff0000 : 32'hffffffff;
         chk(r & m, w & m);
         chk({28'h0, oe}, {28'h0, (i == 2) ? dbs_pkg::LANES_UPPER : dbs_pkg::LANES_ALL});
      end
      $display("test read done");
   endtask

   task automatic t_abort();
      int          lows;
      logic [31:0] r;
      logic [3:0]  oe;
      lows = 0;
      code <= dbs_pkg::ACK_P8;
      waits <= 4'h8;
      while (bclk !== 1'b0) tick();
      cs_n <= 1'b0;
      rw <= 1'b1;
      while (bclk !== 1'b1) tick();
      repeat (3) tick();
      cs_n <= 1'b1;
      repeat (60) begin
         tick();
         if (ta_n !== 1'b1) lows++;
      end
      chk(32'(lows), 32'h0);
      waits <= 4'h0;
      access('{1'b1, 2'h0, 2'h0}, 32'h0, 0, 1'b0, r, oe);
      chk(r, rd_word);
      $display("test abort done");
   endtask

   task automatic t_late();
      logic [31:0] r;
      logic [3:0]  oe;
      code <= dbs_pkg::ACK_P16;
      access('{1'b1, 2'h0, 2'h0}, 32'h0, 20, 1'b0, r, oe);
      chk(r, rd_word);
      $display("test late release done");
   endtask

   // ==========================================================================
   // Sequence and verdict
   task automatic wrap_up();
      $display("counts checked=%0d err_total=%0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (5) tick();
      resetn <= 1'b1;
      repeat (2) tick();
      t_reset();
      t_write();
      t_read();
      t_abort();
      t_late();
      wrap_up();
   end
endmodule
